// [src/sfc_pkg.sv]
// shared constants and types for the serial frame control link
package sfc_pkg;
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 3;
  localparam int WORD_BITS = 16;
  localparam int FRAME_CLOCKS = 20;
  localparam int TRACK_RISE = 13;
  localparam int SHUTDOWN_FALL = 10;
  localparam int NOISE_FALL = 2;
  localparam int CORE_CLK_MHZ = 25;
  localparam int CORE_CLK_NS = 40;
  localparam int ACQUISITION_TIME_NS = 350;
  localparam int QUIET_GAP_TIME_NS = 50;
  // least times round up to whole core cycles
  localparam int ACQ_CYCLES = (ACQUISITION_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int QUIET_CYCLES = (QUIET_GAP_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int FULL_SCALE_CODES = 4096;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  typedef enum logic [1:0] {
    SFC_MODE_NORMAL = 2'b00,
    SFC_MODE_SHUTDOWN = 2'b01
  } sfc_mode_t;
  typedef enum logic [2:0] {
    SFC_M_IDLE = 3'b000,
    SFC_M_SETUP = 3'b001,
    SFC_M_LOW = 3'b010,
    SFC_M_HIGH = 3'b011,
    SFC_M_GAP = 3'b100
  } sfc_mstate_t;
endpackage

// [src/sfc_link_if.sv]
// serial link between converter end and host master end
`timescale 1ns/100ps
interface sfc_link_if;
  logic selectN;
  logic serialClk;
  logic serialDataOut;
  logic serialDataOe;
  logic serialLine;
  // pulled low when nobody drives the line
  assign serialLine = serialDataOe ? serialDataOut : 1'b0;
  modport device (input selectN, input serialClk, output serialDataOut, output serialDataOe);
  modport host (output selectN, output serialClk, input serialLine);
endinterface

// [src/sfc_device.sv]
// converter end: conversion sequencing, mode control and serial readout
// Operation
// - select fall samples input, enters hold, converts
// - back to track on 13th rising clock
// - master allows 350 ns acquisition time
// - data output driven when select falls
// - release output after 16th fall or select rise
// - three zeros then twelve bits, msb first
// - shift on falling edge, capture next falling
// - master supplies sixteen clocks per word
// - master tolerates extra fourth leading zero
// - master waits quiet gap before next select
// - select spacing: hold, track, padding sum
// - twenty clock frame gives full throughput
// - shorter frames allowed if timing met
// - straight binary, step is reference over 4096
// - two modes; select low enters normal
// - rise between 2nd and 10th fall enters shutdown
// - shutdown holds until select falls again
// - rise between 10th and 16th aborts, stays normal
// - master raises select before next conversion
// - rise before second fall keeps mode
// - shutdown aborts conversion, releases output
// - master discards first result after shutdown; host still strobes it with resultValid, flagged by resultDummy
`timescale 1ns/100ps
module sfc_device
  import sfc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link
  sfc_link_if.device link,
  // analog core side
  input wire logic [RESULT_BITS-1:0] analogCode,
  output logic sampleHold,
  output logic trackPhase,
  output logic shutdownMode,
  output logic powerUpDummy
);
  typedef struct packed {
    logic [1:0] selSync;
    logic [1:0] clkSync;
    logic selPrev;
    logic clkPrev;
    logic active;
    logic hold;
    logic drive;
    logic dout;
    logic [4:0] fallCnt;
    logic [4:0] riseCnt;
    logic [WORD_BITS-1:0] shift;
    sfc_mode_t mode;
    logic modeAtStart;
    logic dummy;
    logic sample;
  } sfc_dev_state_t;

  // state after reset: select and clock seen at their idle high level
  localparam sfc_dev_state_t DEV_RESET = '{
    selSync: 2'b11,
    clkSync: 2'b11,
    selPrev: 1'b1,
    clkPrev: 1'b1,
    active: 1'b0,
    hold: 1'b0,
    drive: 1'b0,
    dout: 1'b0,
    fallCnt: 5'h00,
    riseCnt: 5'h00,
    shift: '0,
    mode: SFC_MODE_NORMAL,
    modeAtStart: 1'b0,
    dummy: 1'b0,
    sample: 1'b0
  };

  sfc_dev_state_t st_reg;
  sfc_dev_state_t st_next;
  logic selNow;
  logic clkNow;
  logic selFall;
  logic selRise;
  logic clkFall;
  logic clkRise;

  // edge of a synchronised level against its previous sample
  function automatic logic fellFrom(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic roseFrom(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  // one more edge counted, held at the top of the range
  function automatic logic [4:0] bumpCount(input logic [4:0] count);
    return (count == 5'h1f) ? count : count + 5'h01;
  endfunction

  // true when the edge being counted now is the given one
  function automatic logic reachesCount(input logic [4:0] count, input int target);
    return bumpCount(count) == 5'(target);
  endfunction

  function automatic logic [WORD_BITS-1:0] shiftOn(input logic [WORD_BITS-1:0] word);
    return {word[WORD_BITS-2:0], 1'b0};
  endfunction

  // word to send: leading zeros, result msb first, trailing zero
  function automatic logic [WORD_BITS-1:0] loadWord(input logic [RESULT_BITS-1:0] code);
    return {{LEAD_ZEROS{1'b0}}, code, 1'b0};
  endfunction

  // mode left behind when select rises after so many falling edges
  function automatic sfc_mode_t modeOnRise(input logic [4:0] falls, input logic startedDown);
    sfc_mode_t result;
    result = SFC_MODE_NORMAL;
    if (falls < 5'(NOISE_FALL))
    begin
      result = startedDown ? SFC_MODE_SHUTDOWN : SFC_MODE_NORMAL;
    end
    else if (falls < 5'(SHUTDOWN_FALL))
    begin
      result = SFC_MODE_SHUTDOWN;
    end
    else
    begin
      result = SFC_MODE_NORMAL;
    end
    return result;
  endfunction

  assign selNow = st_reg.selSync[1];
  assign clkNow = st_reg.clkSync[1];
  assign selFall = fellFrom(st_reg.selPrev, selNow);
  assign selRise = roseFrom(st_reg.selPrev, selNow);
  assign clkFall = fellFrom(st_reg.clkPrev, clkNow);
  assign clkRise = roseFrom(st_reg.clkPrev, clkNow);

  always_comb
  begin
    st_next = st_reg;
    st_next.selSync = {st_reg.selSync[0], link.selectN};
    st_next.clkSync = {st_reg.clkSync[0], link.serialClk};
    st_next.selPrev = selNow;
    st_next.clkPrev = clkNow;
    st_next.sample = 1'b0;
    if (selFall)
    begin
      // straight binary code captured at the sampling instant
      st_next.sample = 1'b1;
      st_next.hold = 1'b1;
      st_next.active = 1'b1;
      st_next.drive = 1'b1;
      st_next.fallCnt = 5'h00;
      st_next.riseCnt = 5'h00;
      st_next.shift = loadWord(analogCode);
      st_next.dout = 1'b0;
      st_next.modeAtStart = (st_reg.mode == SFC_MODE_SHUTDOWN);
      st_next.dummy = (st_reg.mode == SFC_MODE_SHUTDOWN);
      st_next.mode = SFC_MODE_NORMAL;
    end
    else if (selRise && st_reg.active)
    begin
      st_next.active = 1'b0;
      st_next.drive = 1'b0;
      st_next.hold = 1'b0;
      st_next.mode = modeOnRise(st_reg.fallCnt, st_reg.modeAtStart);
    end
    else if (st_reg.active && !selNow)
    begin
      if (clkRise && st_reg.riseCnt < 5'h1f)
      begin
        st_next.riseCnt = bumpCount(st_reg.riseCnt);
        if (reachesCount(st_reg.riseCnt, TRACK_RISE))
          st_next.hold = 1'b0;
      end
      if (clkFall && st_reg.fallCnt < 5'h1f)
      begin
        st_next.fallCnt = bumpCount(st_reg.fallCnt);
        // each falling edge presents the next bit
        st_next.dout = st_reg.shift[WORD_BITS-1];
        st_next.shift = shiftOn(st_reg.shift);
        if (reachesCount(st_reg.fallCnt, WORD_BITS))
          st_next.drive = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_reg <= DEV_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.serialDataOut = st_reg.dout;
  assign link.serialDataOe = st_reg.drive;
  assign sampleHold = st_reg.sample;
  assign trackPhase = ~st_reg.hold;
  assign shutdownMode = (st_reg.mode == SFC_MODE_SHUTDOWN);
  assign powerUpDummy = st_reg.dummy;
endmodule

// [src/sfc_host.sv]
// host end: frames conversions, makes serial clock, assembles results
`timescale 1ns/100ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CLOCKS,
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link
  sfc_link_if.host link,
  // user side
  input wire logic startReq,
  input wire logic shutdownReq,
  output logic busy,
  output logic [RESULT_BITS-1:0] resultData,
  output logic resultValid,
  output logic resultDummy
);
  typedef struct packed {
    logic [1:0] dataSync;
    sfc_mstate_t state;
    logic sel;
    logic sclk;
    logic [3:0] div;
    logic [4:0] cycles;
    logic [WORD_BITS-1:0] word;
    logic [5:0] gap;
    logic stop;
    logic wasDown;
    logic [RESULT_BITS-1:0] result;
    logic valid;
    logic dummy;
  } sfc_host_state_t;

  sfc_host_state_t st_reg;
  sfc_host_state_t st_next;
  logic halfTick;

  assign halfTick = (st_reg.div == 4'(HALF_CYCLES - 1));

  always_comb
  begin
    st_next = st_reg;
    st_next.dataSync = {st_reg.dataSync[0], link.serialLine};
    st_next.valid = 1'b0;
    st_next.div = halfTick ? 4'h0 : st_reg.div + 4'h1;
    case (st_reg.state)
      SFC_M_IDLE:
      begin
        st_next.sclk = 1'b1;
        st_next.sel = 1'b1;
        st_next.div = 4'h0;
        if (startReq)
        begin
          // select falls while clock is high so first falling edge follows
          st_next.sel = 1'b0;
          st_next.stop = shutdownReq;
          st_next.cycles = 5'h00;
          st_next.word = '0;
          st_next.state = SFC_M_SETUP;
        end
      end
      SFC_M_SETUP:
        if (halfTick)
        begin
          st_next.sclk = 1'b0;
          st_next.state = SFC_M_LOW;
        end
      SFC_M_LOW:
        if (halfTick)
        begin
          st_next.sclk = 1'b1;
          st_next.cycles = st_reg.cycles + 5'h01;
          st_next.state = SFC_M_HIGH;
        end
      SFC_M_HIGH:
        if (halfTick)
        begin
          // capture the bit shifted on the previous falling edge
          st_next.word = {st_reg.word[WORD_BITS-2:0], st_reg.dataSync[1]};
          if (st_reg.stop && st_reg.cycles == 5'(NOISE_FALL + 1))
          begin
            st_next.sel = 1'b1;
            st_next.wasDown = 1'b1;
            st_next.gap = 6'(ACQ_CYCLES);
            st_next.state = SFC_M_GAP;
          end
          else if (st_reg.cycles == 5'(FRAME_LEN))
          begin
            st_next.sel = 1'b1;
            st_next.gap = 6'(ACQ_CYCLES + QUIET_CYCLES);
            st_next.state = SFC_M_GAP;
          end
          else
          begin
            st_next.sclk = 1'b0;
            st_next.state = SFC_M_LOW;
            if (st_reg.cycles == 5'(WORD_BITS))
            begin
              // fifteen bits in: drop the zeros and hand over the code
              st_next.result = st_reg.word[RESULT_BITS-1:0];
              st_next.valid = 1'b1;
              st_next.dummy = st_reg.wasDown;
              st_next.wasDown = 1'b0;
            end
          end
        end
      SFC_M_GAP:
      begin
        st_next.sclk = 1'b1;
        if (st_reg.gap == 6'h00)
          st_next.state = SFC_M_IDLE;
        else
          st_next.gap = st_reg.gap - 6'h01;
      end
      default:
        st_next.state = SFC_M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_reg <= '{dataSync: 2'b00, state: SFC_M_IDLE, sel: 1'b1, sclk: 1'b1, div: 4'h0,
        cycles: 5'h00, word: '0, gap: 6'h00, stop: 1'b0, wasDown: 1'b1,
        result: RESULT_RESET, valid: 1'b0, dummy: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.selectN = st_reg.sel;
  assign link.serialClk = st_reg.sclk;
  assign busy = (st_reg.state != SFC_M_IDLE);
  assign resultData = st_reg.result;
  assign resultValid = st_reg.valid;
  assign resultDummy = st_reg.dummy;
endmodule

// [test/sfc_link_assertions.sv]
// checker of the link wire between converter end and host end
`timescale 1ns/100ps
module sfc_link_assertions
  import sfc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic serialLine
);
  logic clkPrev;
  logic armed;
  logic [4:0] fallCnt;
  logic [4:0] riseCnt;
  logic [7:0] gapCnt;
  wire rise13 = !selectN && !clkPrev && serialClk && riseCnt == 5'h0c;
  always_ff @(posedge core_clk)
  begin
    clkPrev <= reset | serialClk;
    armed <= !reset && (armed || rise13);
    gapCnt <= (reset || rise13) ? 8'h00 : gapCnt + {7'h00, gapCnt != 8'hff};
    if (reset || selectN)
    begin
      fallCnt <= 5'h00;
      riseCnt <= 5'h00;
    end
    else
    begin
      fallCnt <= fallCnt + {4'h0, clkPrev && !serialClk};
      riseCnt <= riseCnt + {4'h0, !clkPrev && serialClk};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_DRIVE_ON: assert property ($fell(selectN) |-> ##[1:5] serialDataOe)
    else $error("data line not driven after select fall");
  AST_RELEASE_ON_RISE: assert property ($rose(selectN) |-> ##[0:5] !serialDataOe)
    else $error("data line still driven after select rise");
  AST_IDLE_RELEASED: assert property (selectN [*6] |-> !serialDataOe)
    else $error("data line driven while not selected");
  AST_HOLD_WHILE_HIGH: assert property (serialClk && $past(serialClk) && serialDataOe
    && $past(serialDataOe) |-> $stable(serialDataOut))
    else $error("data changed while clock high");
  AST_LEAD_ZEROS: assert property ($fell(serialClk) && !selectN && fallCnt < 5'h04
    |-> !$past(serialLine))
    else $error("leading bit not zero");
  AST_RELEASE_AFTER_16: assert property (fallCnt == 5'h10 && $past(fallCnt) == 5'h0f
    |-> ##[0:6] !serialDataOe)
    else $error("data line driven after last bit");
  AST_SELECT_ON_HIGH_CLK: assert property ($fell(selectN) |-> serialClk)
    else $error("select fell with clock low");
  AST_ACQ_GAP: assert property ($fell(selectN) && armed |-> gapCnt >= 8'(ACQ_CYCLES))
    else $error("acquisition gap too short");
  AST_FRAME_LENGTH: assert property ($rose(selectN) |-> fallCnt >= 5'h10
    || (fallCnt >= 5'h02 && fallCnt < 5'h0a))
    else $error("frame cut outside allowed window");
  cover property ($rose(selectN) && fallCnt >= 5'h10);
  cover property ($rose(selectN) && fallCnt < 5'h0a);
  cover property ($fell(selectN) && armed);
endmodule

// [test/sar_adc_serial_frame_control_tb_top.sv]
// self-checking bench joining converter end and host end
`timescale 1ns/100ps
module sar_adc_serial_frame_control_tb_top
  import sfc_pkg::*;
();
  logic core_clk;
  logic reset;
  logic startReq;
  logic shutdownReq;
  logic [RESULT_BITS-1:0] analogCode;
  logic sampleHold, trackPhase, shutdownMode, powerUpDummy;
  logic busy, resultValid, resultDummy;
  logic [RESULT_BITS-1:0] resultData;
  logic [11:0] codes [4] = '{12'hfff, 12'h000, 12'h801, 12'h3c3};
  int failures, checkCount, cycles;
  sfc_link_if sfc_link_if_inst ();
  sfc_device sfc_device_inst (.core_clk(core_clk), .reset(reset),
    .link(sfc_link_if_inst.device), .analogCode(analogCode), .sampleHold(sampleHold),
    .trackPhase(trackPhase), .shutdownMode(shutdownMode), .powerUpDummy(powerUpDummy));
  sfc_host sfc_host_inst (.core_clk(core_clk), .reset(reset), .link(sfc_link_if_inst.host),
    .startReq(startReq), .shutdownReq(shutdownReq), .busy(busy), .resultData(resultData),
    .resultValid(resultValid), .resultDummy(resultDummy));
  sfc_link_assertions sfc_link_assertions_inst (.core_clk(core_clk), .reset(reset),
    .selectN(sfc_link_if_inst.selectN), .serialClk(sfc_link_if_inst.serialClk),
    .serialDataOut(sfc_link_if_inst.serialDataOut),
    .serialDataOe(sfc_link_if_inst.serialDataOe), .serialLine(sfc_link_if_inst.serialLine));
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one frame: sd asks for shutdown, dum is discard flag, pd the device power-up flag
  task automatic run_frame(input logic [11:0] code, input logic sd, input logic dum,
    input logic pd);
    int n;
    logic seenValid;
    n = 0;
    seenValid = 1'b0;
    @(posedge core_clk);
    analogCode <= code;
    startReq <= 1'b1;
    shutdownReq <= sd;
    @(posedge core_clk);
    startReq <= 1'b0;
    shutdownReq <= 1'b0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (sampleHold !== 1'b1 && n < 20);
    check("sample pulse", 12'(sampleHold), 12'h001);
    @(negedge core_clk);
    check("hold phase", 12'(trackPhase), 12'h000);
    check("power-up flag", 12'(powerUpDummy), 12'(pd));
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
      if (resultValid === 1'b1)
      begin
        seenValid = 1'b1;
        check("result", resultData, code);
        check("discard flag", 12'(resultDummy), 12'(dum));
        check("track phase", 12'(trackPhase), 12'h001);
      end
    end
    while (busy !== 1'b0 && n < 400);
    check("busy end", 12'(busy), 12'h000);
    check("result strobe", 12'(seenValid), 12'(!sd));
    check("shutdown mode", 12'(shutdownMode), 12'(sd));
    $display("test frame %h done", code);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("unexpected run length: expected %0d seen %0d", 19999, cycles);
      stopTest();
    end
  end
  initial
  begin
    reset = 1'b1;
    startReq = 1'b0;
    shutdownReq = 1'b0;
    analogCode = 12'h000;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    run_frame(12'ha5c, 1'b0, 1'b1, 1'b0);
    foreach (codes[i])
      run_frame(codes[i], 1'b0, 1'b0, 1'b0);
    run_frame(12'h555, 1'b1, 1'b0, 1'b0);
    run_frame(12'h2aa, 1'b0, 1'b1, 1'b1);
    run_frame(12'h7e1, 1'b0, 1'b0, 1'b0);
    stopTest();
  end
endmodule
